// file: hdl/ssp_port.v
// serial peripheral port: axi4-lite registers, master/slave shifter, flags
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defines.vh"
module ssp_port #(
  parameter DIVW = 7
) (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // cpu side interrupt
  output reg         irq_req,
  input  wire        irq_ack,
  // serial pins
  input  wire        sck_in,
  output reg         sck_out,
  output reg         sck_oe,
  input  wire        mosi_in,
  output reg         mosi_out,
  output reg         mosi_oe,
  input  wire        miso_in,
  output reg         miso_out,
  output reg         miso_oe,
  input  wire        ss_n_in
);
  // one-hot shifter states
  localparam ST_IDLE = 3'b001;
  localparam ST_MSH  = 3'b010;
  localparam ST_SLV  = 3'b100;

  // software visible state and shifter storage
  reg  [7:0]      ctrl_r;
  reg             dbl_r;
  reg  [1:0]      cfg_r;
  reg             done_r;
  reg             write_collision_flag_r;
  reg             armed_r;
  reg  [2:0]      state_r;
  reg  [7:0]      shreg_r;
  reg  [7:0]      rxbuf_r;
  reg  [3:0]      edges_r;
  reg  [DIVW-1:0] div_r;
  reg             sck_prev_r;

  // axi write capture, held until the response
  reg             aw_got_r;
  reg             w_got_r;
  reg  [3:0]      awaddr_r;
  reg  [7:0]      wbyte_r;
  reg             wlane_r;

  // decoded control fields
  wire       en      = ctrl_r[`SSP_CTRL_EN];
  wire       master  = ctrl_r[`SSP_CTRL_MASTER];
  wire       clock_idle_level    = ctrl_r[`SSP_CTRL_CLOCK_IDLE_LEVEL];
  wire       clock_sample_edge    = ctrl_r[`SSP_CTRL_CLOCK_SAMPLE_EDGE];
  wire       lsbf    = ctrl_r[`SSP_CTRL_ORDER];
  wire       busy    = (state_r != ST_IDLE);
  wire [7:0] status  = {done_r, write_collision_flag_r, 5'h00, dbl_r};

  // half period in system clocks, minus one
  // the divider restarts with each byte so the first half period is whole
  reg [DIVW-1:0] half_lim;
  always @* begin
    case ({dbl_r, ctrl_r[1:0]})
      3'b000:  half_lim = 7'h01;
      3'b001:  half_lim = 7'h07;
      3'b010:  half_lim = 7'h1f;
      3'b011:  half_lim = 7'h3f;
      3'b100:  half_lim = 7'h00;
      3'b101:  half_lim = 7'h03;
      3'b110:  half_lim = 7'h0f;
      default: half_lim = 7'h1f;
    endcase
  end

  // write handshake: address and data accepted in either order
  wire wr_go = aw_got_r && w_got_r && !s_axi_bvalid;
  wire rd_go = s_axi_arvalid && s_axi_arready;
  // writes decode the captured address, reads the live one held until taken
  wire wr_ctrl = wr_go && (awaddr_r == `SSP_OFF_CTRL) && wlane_r;
  wire wr_stat = wr_go && (awaddr_r == `SSP_OFF_STAT) && wlane_r;
  wire wr_data = wr_go && (awaddr_r == `SSP_OFF_DATA) && wlane_r;
  wire wr_cfg  = wr_go && (awaddr_r == `SSP_OFF_CFG) && wlane_r;
  wire rd_stat = rd_go && (s_axi_araddr == `SSP_OFF_STAT);
  wire rd_data = rd_go && (s_axi_araddr == `SSP_OFF_DATA);
  wire data_acc = wr_data || rd_data;

  // a master whose select input is pulled low yields the bus
  wire mode_fault = en && master && cfg_r[`SSP_CFG_SS_IN] && !ss_n_in;
  // a master byte starts only from idle; a busy write is a collision instead
  wire start_m = wr_data && en && master && !busy && !mode_fault;

  // slave pin edges; sck_in is already synchronous to aclk
  wire sck_rise = sck_in && !sck_prev_r;
  wire sck_fall = !sck_in && sck_prev_r;
  wire lead_s   = clock_idle_level ? sck_fall : sck_rise;
  wire trail_s  = clock_idle_level ? sck_rise : sck_fall;
  wire slave_sel = en && !master && !ss_n_in;

  // master toggle tick
  wire tick = (div_r == half_lim);
  // odd edge count = leading edge done so far
  wire m_lead  = tick && !edges_r[0];
  wire sample_m = (state_r == ST_MSH) && tick && (edges_r[0] == clock_sample_edge);
  wire setup_m  = (state_r == ST_MSH) && tick && (edges_r[0] != clock_sample_edge) && edges_r != 4'hf;

  // slave shifts on the edges seen on sck_in
  wire sample_s = (state_r == ST_SLV) && (clock_sample_edge ? trail_s : lead_s);
  wire setup_s  = (state_r == ST_SLV) && (clock_sample_edge ? lead_s : trail_s);
  wire sample   = sample_m || sample_s;
  wire in_bit   = master ? miso_in : mosi_in;
  wire out_bit  = lsbf ? shreg_r[0] : shreg_r[7];
  wire [7:0] shifted = lsbf ? {in_bit, shreg_r[7:1]} : {shreg_r[6:0], in_bit};
  // end of byte: sixteenth master edge or eighth slave sample
  wire last_m  = (state_r == ST_MSH) && tick && (edges_r == 4'hf);
  wire [2:0] scount = edges_r[2:0];
  wire last_s  = sample_s && (scount == 3'h7);
  wire finish  = last_m || last_s;

  // axi channel handshakes
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SSP_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `SSP_RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      awaddr_r      <= 4'h0;
      wbyte_r       <= 8'h00;
      wlane_r       <= 1'b0;
    end else begin
      s_axi_awready <= !aw_got_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_got_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wbyte_r <= s_axi_wdata[7:0];
        wlane_r <= s_axi_wstrb[0];
      end
      // the response goes out once both halves are in
      if (wr_go) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_r[1:0] == 2'b00) ? `SSP_RESP_OKAY : `SSP_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // one read at a time: no new address while data waits
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `SSP_RESP_OKAY;
        // unmapped words read zero with an error response
        if (s_axi_araddr == `SSP_OFF_CTRL)
          s_axi_rdata <= {24'h000000, ctrl_r};
        else if (s_axi_araddr == `SSP_OFF_STAT)
          s_axi_rdata <= {24'h000000, status};
        else if (s_axi_araddr == `SSP_OFF_DATA)
          s_axi_rdata <= {24'h000000, rxbuf_r};
        else if (s_axi_araddr == `SSP_OFF_CFG)
          s_axi_rdata <= {30'h00000000, cfg_r};
        else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `SSP_RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // control, flags and clear sequence
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r  <= `SSP_CTRL_RST;
      dbl_r   <= 1'b0;
      cfg_r   <= 2'b00;
      done_r  <= 1'b0;
      write_collision_flag_r  <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      // software writes; a mode fault drops master select
      if (wr_ctrl)
        ctrl_r <= wbyte_r;
      else if (mode_fault)
        ctrl_r[`SSP_CTRL_MASTER] <= 1'b0;
      if (wr_stat)
        dbl_r <= wbyte_r[`SSP_STAT_DBL];
      if (wr_cfg)
        cfg_r <= wbyte_r[1:0];
      // arm the clear when status is read showing a flag
      if (rd_stat && (done_r || write_collision_flag_r))
        armed_r <= 1'b1;
      else if (data_acc)
        armed_r <= 1'b0;
      // setting wins over every clear
      if (finish || mode_fault)
        done_r <= 1'b1;
      else if (irq_ack || (data_acc && armed_r))
        done_r <= 1'b0;
      if (wr_data && en && busy)
        write_collision_flag_r <= 1'b1;
      else if (data_acc && armed_r)
        write_collision_flag_r <= 1'b0;
    end
  end

  // shifter state machine and pins
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_r    <= ST_IDLE;
      shreg_r    <= 8'h00;
      rxbuf_r    <= 8'h00;
      edges_r    <= 4'h0;
      div_r      <= 7'h00;
      sck_prev_r <= 1'b0;
      sck_out    <= 1'b0;
      sck_oe     <= 1'b0;
      mosi_out   <= 1'b0;
      mosi_oe    <= 1'b0;
      miso_out   <= 1'b0;
      miso_oe    <= 1'b0;
      irq_req    <= 1'b0;
    end else begin
      sck_prev_r <= sck_in;
      irq_req <= done_r && ctrl_r[`SSP_CTRL_IRQEN] && cfg_r[`SSP_CFG_GIE];
      // pins drive only while enabled; miso only when selected
      sck_oe  <= en && master;
      mosi_oe <= en && master;
      miso_oe <= slave_sel;
      // clock rests at its idle level outside a master byte
      if (!(state_r == ST_MSH))
        sck_out <= clock_idle_level;
      if (sample)
        shreg_r <= shifted;
      // a master byte in phase 0 ends on a trailing edge with nothing new to sample
      if (finish)
        rxbuf_r <= sample ? shifted : shreg_r;
      case (state_r)
        ST_IDLE: begin
          edges_r <= 4'h0;
          div_r   <= 7'h00;
          if (start_m) begin
            shreg_r  <= wbyte_r;
            state_r  <= ST_MSH;
            // phase 0 presents the first bit before the leading edge
            mosi_out <= lsbf ? wbyte_r[0] : wbyte_r[7];
          end else begin
            // a slave keeps its reply byte until a master selects it
            if (wr_data && en && !master)
              shreg_r <= wbyte_r;
            if (slave_sel) begin
              state_r  <= ST_SLV;
              // phase 0 needs the first reply bit before the first edge
              if (wr_data)
                miso_out <= lsbf ? wbyte_r[0] : wbyte_r[7];
              else
                miso_out <= out_bit;
            end
          end
        end
        ST_MSH: begin
          // each tick is one serial clock edge
          div_r <= tick ? 7'h00 : div_r + 7'h01;
          if (tick) begin
            sck_out <= m_lead ? !clock_idle_level : clock_idle_level;
            edges_r <= edges_r + 4'h1;
          end
          if (setup_m)
            mosi_out <= out_bit;
          // disable or a mode fault cuts the byte short
          if (!en || mode_fault || last_m)
            state_r <= ST_IDLE;
        end
        ST_SLV: begin
          // the slave bit count lives in the low edge bits
          if (sample_s)
            edges_r <= {1'b0, scount + 3'h1};
          if (setup_s)
            miso_out <= out_bit;
          // select high drops a partial byte at once
          if (ss_n_in || !en || master || last_s)
            state_r <= ST_IDLE;
        end
        // an illegal code falls back to idle
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: hdl/ssp_defines.vh
// register map, field positions and reset values of the serial peripheral port
`ifndef SSP_DEFINES_VH
`define SSP_DEFINES_VH
`define SSP_OFF_CTRL      4'h0
`define SSP_OFF_STAT      4'h4
`define SSP_OFF_DATA      4'h8
`define SSP_OFF_CFG       4'hc
`define SSP_CTRL_IRQEN    7
`define SSP_CTRL_EN       6
`define SSP_CTRL_ORDER    5
`define SSP_CTRL_MASTER   4
`define SSP_CTRL_CLOCK_IDLE_LEVEL     3
`define SSP_CTRL_CLOCK_SAMPLE_EDGE     2
`define SSP_STAT_DONE     7
`define SSP_STAT_WRITE_COLLISION_FLAG     6
`define SSP_STAT_DBL      0
`define SSP_CFG_GIE       0
`define SSP_CFG_SS_IN     1
`define SSP_CTRL_RST      8'h00
`define SSP_RESP_OKAY     2'b00
`define SSP_RESP_SLVERR   2'b10
`define SSP_BITS          4'h8
`endif

// file: sim/ssp_port_props.sv
// concurrent checks on the serial peripheral port, bound to its ports
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defines.vh"
module ssp_port_props (
  // clock, reset and register bus (grouped several to a line to stay compact)
  input wire logic        aclk, aresetn,
  input wire logic [3:0]  s_axi_awaddr, s_axi_araddr,
  input wire logic [31:0] s_axi_wdata, s_axi_rdata,
  input wire logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic        s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
  // interrupt and serial pins
  input wire logic        irq_req, irq_ack, sck_out, sck_oe, mosi_oe, miso_oe
);
  logic [7:0] ctrl_r, cfg_r, gap_r;
  logic [4:0] edg_r;
  logic [3:0] rda_r;
  logic       dbl_r, sck_q_r;
  wire        wr_go = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
  wire        tog   = sck_oe & (sck_out ^ sck_q_r);
  // code 11 is off the power-of-four ladder, so it is picked out by hand
  wire [7:0]  half  = (ctrl_r[1:0] == 2'b11 ? 8'h40 : 8'h02 << {ctrl_r[1:0], 1'b0}) >> dbl_r;
  // shadow settings; only edges after the first of a transfer are timed
  always_ff @(posedge aclk) begin
    sck_q_r <= sck_out;
    gap_r   <= tog ? 8'h01 : gap_r + 8'h01;
    if (s_axi_arvalid & s_axi_arready) rda_r <= s_axi_araddr;
    if (!aresetn) begin
      ctrl_r <= 8'h00;
      cfg_r  <= 8'h00;
      dbl_r  <= 1'b0;
      edg_r  <= 5'h00;
    end else begin
      if (wr_go && s_axi_awaddr == `SSP_OFF_CTRL) ctrl_r <= s_axi_wdata[7:0];
      if (wr_go && s_axi_awaddr == `SSP_OFF_CFG) cfg_r <= s_axi_wdata[7:0];
      if (wr_go && s_axi_awaddr == `SSP_OFF_STAT) dbl_r <= s_axi_wdata[0];
      if (wr_go && s_axi_awaddr == `SSP_OFF_DATA) edg_r <= 5'h00;
      else if (tog) edg_r <= edg_r + 5'h01;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rst_quiet; $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !sck_oe; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
  property p_b_follow; s_axi_awready && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
  a_b_follow: assert property (p_b_follow) else $error("write response late");
  property p_r_follow; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_follow: assert property (p_r_follow) else $error("read data late");
  property p_stat_zero; s_axi_rvalid && rda_r == `SSP_OFF_STAT |->
    s_axi_rdata[31:8] == 24'h000000 && s_axi_rdata[5:1] == 5'h00; endproperty
  a_stat_zero: assert property (p_stat_zero) else $error("status spare bits set");
  property p_irq_gate; irq_req |-> ctrl_r[7] && cfg_r[0]; endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt while masked");
  property p_irq_ack; irq_ack |-> ##[1:2] !irq_req; endproperty
  a_irq_ack: assert property (p_irq_ack) else $error("interrupt survives ack");
  property p_en_gate; !ctrl_r[6] && !$past(ctrl_r[6]) && !$past(ctrl_r[6], 2) |->
    !sck_oe && !mosi_oe && !miso_oe; endproperty
  a_en_gate: assert property (p_en_gate) else $error("pins driven while off");
  property p_rate; tog && edg_r != 5'h00 && edg_r < 5'h10 |-> gap_r == half; endproperty
  a_rate: assert property (p_rate) else $error("serial clock rate wrong");
endmodule
bind ssp_port ssp_port_props u_props (.*);
`default_nettype wire

// file: sim/ssp_slave_model.sv
// behavioural serial slave facing the port while it is master
`timescale 1ns/1ps
`default_nettype none
module ssp_slave_model (
  input  wire logic       sck, mosi, sel_n, clock_idle_level, clock_sample_edge,
  input  wire logic [7:0] tx,
  output var  logic       miso,
  output var  logic [7:0] rx
);
  logic [7:0] sh = 8'h00;
  initial miso = 1'b0;
  initial rx = 8'h00;
  // phase 0 needs the first bit out before the first edge arrives
  always @(negedge sel_n) begin
    sh = tx;
    miso = tx[7];
  end
  // a released line shows the inverse so stale data never passes
  always @(posedge sel_n) miso = ~miso;
  // leading edge leaves the idle level; phase picks sample or setup
  always @(sck) if (!sel_n) begin
    if (sck ^ clock_idle_level ^ clock_sample_edge) rx = {rx[6:0], mosi};
    else begin
      if (!clock_sample_edge) sh = {sh[6:0], 1'b0};
      miso = sh[7];
      if (clock_sample_edge) sh = {sh[6:0], 1'b0};
    end
  end
endmodule
`default_nettype wire

// file: sim/ssp_port_tb_top.sv
// self-checking bench for the serial peripheral port
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defines.vh"
module ssp_port_tb_top;
  logic aclk = 1'b0, aresetn = 1'b0, irq_ack = 1'b0, ss_n_in = 1'b1, sel_n = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, clock_idle_level = 1'b0, clock_sample_edge = 1'b0;
  logic sck_in = 1'b0, mosi_in = 1'b0;
  wire miso_out;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, rdv;
  logic [7:0] tx = 8'h2d;
  logic [1:0] rrs;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_req;
  wire sck_out, sck_oe, mosi_out, mosi_oe, miso_in, miso_oe;
  wire [1:0] s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] prx;
  int fail_count = 0, num_checks = 0;
  ssp_port dut (.*, .s_axi_wstrb(4'h1), .s_axi_bresp());
  ssp_slave_model u_slv (.sck(sck_out), .mosi(mosi_out), .sel_n(sel_n), .clock_idle_level(clock_idle_level),
    .clock_sample_edge(clock_sample_edge), .tx(tx), .miso(miso_in), .rx(prx));
  initial forever #20 aclk = ~aclk;
  task automatic chk(input string n, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  // each channel is dropped at the edge that takes it; the response ends the write
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rdv = s_axi_rdata;
    rrs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rc(input string n, input logic [3:0] a, input logic [7:0] e);
    rd(a);
    chk(n, rdv, {24'h0, e});
  endtask
  // status polling is bounded; the last read also arms the flag clear
  task automatic poll;
    rdv = 32'h0;
    for (int k = 0; k < 600 && rdv[7] !== 1'b1; k++) rd(`SSP_OFF_STAT);
  endtask
  function automatic logic [7:0] rv(input logic [7:0] x);
    for (int k = 0; k < 8; k++) rv[k] = x[7 - k];
  endfunction
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge aclk);
    fail_count++;
    summarize;
  end
  initial begin
    logic [7:0] d, sb;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rc("ctrl reset", `SSP_OFF_CTRL, `SSP_CTRL_RST);
    rd(4'h2);
    chk("bad addr resp", {30'h0, rrs}, {30'h0, `SSP_RESP_SLVERR});
    $display("test registers done");
    // every mode, rate code, speed and bit order against the slave model
    for (int i = 0; i < 8; i++) begin
      d = 8'h31 + i[7:0];
      clock_idle_level <= i[1];
      clock_sample_edge <= i[0];
      wr(`SSP_OFF_STAT, {7'h0, i[2]});
      wr(`SSP_OFF_CTRL, {2'b01, i[2], 1'b1, i[1:0], i[1:0]});
      // let the idle clock level settle before the slave listens
      @(posedge aclk);
      sel_n <= 1'b0;
      wr(`SSP_OFF_DATA, d);
      poll;
      chk("done stat", rdv, {24'h0, 7'h40, i[2]});
      sel_n <= 1'b1;
      chk("slave rx", {24'h0, prx}, {24'h0, i[2] ? rv(d) : d});
      rc("rx data", `SSP_OFF_DATA, i[2] ? rv(tx) : tx);
      rc("stat clear", `SSP_OFF_STAT, {7'h0, i[2]});
    end
    $display("test modes done");
    sel_n <= 1'b0;
    wr(`SSP_OFF_DATA, 8'h5a);
    wr(`SSP_OFF_DATA, 8'ha5);
    poll;
    chk("collision stat", rdv, 32'hc1);
    sel_n <= 1'b1;
    rd(`SSP_OFF_DATA);
    rc("collision clear", `SSP_OFF_STAT, 8'h01);
    $display("test collision done");
    wr(`SSP_OFF_STAT, 8'h00);
    wr(`SSP_OFF_CTRL, 8'hd0);
    @(posedge aclk);
    sel_n <= 1'b0;
    wr(`SSP_OFF_DATA, 8'h11);
    poll;
    sel_n <= 1'b1;
    chk("irq masked", {31'h0, irq_req}, 32'h0);
    wr(`SSP_OFF_CFG, 8'h01);
    repeat (2) @(posedge aclk);
    chk("irq raised", {31'h0, irq_req}, 32'h1);
    irq_ack <= 1'b1;
    @(posedge aclk);
    irq_ack <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("irq acked", {31'h0, irq_req}, 32'h0);
    rc("ack clears", `SSP_OFF_STAT, 8'h00);
    $display("test interrupt done");
    wr(`SSP_OFF_CFG, 8'h02);
    wr(`SSP_OFF_CTRL, 8'h50);
    ss_n_in <= 1'b0;
    repeat (4) @(posedge aclk);
    rc("select stat", `SSP_OFF_STAT, 8'h80);
    rc("select ctrl", `SSP_OFF_CTRL, 8'h40);
    ss_n_in <= 1'b1;
    $display("test select done");
    // the port as slave in mode 0, the bench playing the external master
    d = 8'h3c;
    wr(`SSP_OFF_DATA, 8'h96);
    ss_n_in <= 1'b0;
    for (int k = 7; k >= 0; k--) begin
      mosi_in <= d[k];
      repeat (4) @(posedge aclk);
      sb[k] = miso_out;
      sck_in <= 1'b1;
      repeat (4) @(posedge aclk);
      sck_in <= 1'b0;
    end
    repeat (4) @(posedge aclk);
    ss_n_in <= 1'b1;
    chk("slave tx", {24'h0, sb}, 32'h96);
    rc("slave stat", `SSP_OFF_STAT, 8'h80);
    rc("slave rx", `SSP_OFF_DATA, 8'h3c);
    $display("test slave done");
    summarize;
  end
endmodule
`default_nettype wire
